/* hdl/peak_search_pkg.sv */
package peak_search_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int NCYL = 6;
  localparam int TW = 12;
  localparam int FW = 12;
  localparam int DW = 4;

  // ****************************************
  // temperature thresholds in degrees, drop count and column depth
  // ****************************************
  localparam logic [TW-1:0] RISE_DEG = 12'h00F;
  localparam logic [TW-1:0] SEG_DEG = 12'h005;
  localparam logic [1:0] DROP_N = 2'h2;
  localparam logic [DW-1:0] DEPTH_MAX = 4'hF;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LEANEST_S = 2;
  localparam int unsigned HOLD_S = 5;
  localparam int unsigned LEANEST_CYC = LEANEST_S * CLK_HZ;
  localparam int unsigned HOLD_CYC = HOLD_S * CLK_HZ;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_PEAK = 8'h08;
  localparam logic [7:0] ADR_FLOW = 8'h0C;
  localparam int CTRL_FF_BIT = 0;
  localparam logic CTRL_FF_RST = 1'h0;

  // ****************************************
  // modes and labels
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ARMED = 3'b001, ST_ACTIVE = 3'b010, ST_LEANEST = 3'b011,
    ST_SET = 3'b100, ST_LOP_RUN = 3'b101, ST_LOP_DONE = 3'b110, ST_LOP_BAR = 3'b111
  } state_e;

  typedef enum logic [2:0] {
    LBL_BLANK = 3'b000, LBL_RICH = 3'b001, LBL_LEAN = 3'b010, LBL_ACTIVE = 3'b011,
    LBL_LEANEST = 3'b100, LBL_SET = 3'b101, LBL_PEAK = 3'b110, LBL_FLOW = 3'b111
  } label_e;

endpackage

/* hdl/button_classifier.sv */
`timescale 1ns/1ps
`default_nettype none
module button_classifier #(
  parameter int unsigned HOLD_CYC = peak_search_pkg::HOLD_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic pin,
  output logic pressed,
  output logic tap,
  output logic hold
);

  logic sync_q;
  logic [31:0] cnt_q;
  logic held_q;

  // ****************************************
  // two-stage synchroniser, pressed is stage two
  // ****************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync_q <= 1'b0;
      pressed <= 1'b0;
    end else begin
      sync_q <= pin;
      pressed <= sync_q;
    end
  end

  // tap on release before the hold time, hold pulse once the time is reached
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 32'h0000_0000;
      held_q <= 1'b0;
      tap <= 1'b0;
      hold <= 1'b0;
    end else begin
      tap <= 1'b0;
      hold <= 1'b0;
      if (pressed) begin
        if (!held_q) begin
          if (cnt_q == HOLD_CYC - 1) begin
            hold <= 1'b1;
            held_q <= 1'b1;
            cnt_q <= 32'h0000_0000;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
      end else begin
        // a held press has cnt cleared, so its release is not a tap
        tap <= (cnt_q != 32'h0000_0000);
        cnt_q <= 32'h0000_0000;
        held_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* hdl/mixture_peak_search_fsm.sv */
// Functional notes
// - two methods, rich and lean of peak, each labelled; rich is default.
// - peak-search tap arms and watches every cylinder for a 15 degree rise.
// - after the rise, flash hottest cylinder dot; not active before that.
// - while searching, readout shows current temperature of hottest cylinder.
// - with fuel-flow option, right side shows flow instead of label.
// - detect first cylinder to peak, not necessarily the hottest.
// - first peak shows leanest label two seconds, then flashes column with set.
// - first-to-peak cylinder stays locked in readout for rest of procedure.
// - captured peak stored and shown with peak label while button held.
// - tap then hold both buttons selects lean; each further hold toggles.
// - toggle counts only after five-second dual hold, between entry and leaning.
// - method changes ignored once the active dot is flashing.
// - lean method draws inverted columns, 5 degrees per segment below peak.
// - lean method flashes each dot at peak; last peak flashes its column.
// - lean method, button held: show flow spread and first-to-peak cylinder's peak.
// - after lean completes, step tap resumes scan, peak tap shows bar graph.
// - second peak tap from bar graph restarts procedure from the beginning.
// - step tap in peak-search mode ends it and resumes automatic scan.
// - tap is momentary, hold is five seconds or more.
`timescale 1ns/1ps
`default_nettype none
module mixture_peak_search_fsm #(
  parameter int unsigned LEANEST_CYC = peak_search_pkg::LEANEST_CYC,
  parameter int unsigned HOLD_CYC = peak_search_pkg::HOLD_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic peak_search_button,
  input wire logic step_button,
  input wire logic sample_valid,
  input wire logic [71:0] exhaust_temp,
  input wire logic [11:0] fuel_flow,
  output logic [11:0] readout_left,
  output logic [11:0] readout_right,
  output peak_search_pkg::label_e right_label,
  output logic [5:0] dot_flash,
  output logic [5:0] column_flash,
  output logic column_invert,
  output logic [23:0] invert_depth,
  output logic lean_method,
  output logic scan_resume
);

  localparam int N = peak_search_pkg::NCYL;
  localparam int TW = peak_search_pkg::TW;
  localparam logic [N-1:0] ALL = {N{1'b1}};

  peak_search_pkg::state_e state_q;
  logic lop_q;
  logic ff_opt_q;
  logic [31:0] timer_q;
  logic lf_pressed, lf_tap, step_tap, both_hold, step_pressed;
  logic [TW-1:0] cur [N];
  logic [TW-1:0] base_q [N];
  logic [TW-1:0] max_q [N];
  logic [1:0] drop_q [N];
  logic [N-1:0] risen_q, peaked_q, new_peak, rise_now;
  logic [2:0] first_q, last_q, hot_idx, new_lo, new_hi;
  logic [TW-1:0] hot_temp, peak_val;
  logic [11:0] ff_first_q, ff_last_q, spread;
  logic [23:0] depth_d;
  logic arm, tracking;

  // ****************************************
  // buttons
  // ****************************************
  // a dual hold is its own press classifier, fed by both synchronised presses
  // so that no logic ever reads a raw pin; costs two cycles of extra latency
  button_classifier #(.HOLD_CYC(HOLD_CYC)) u_lf (
    .mclk(mclk), .nrst(nrst), .pin(peak_search_button),
    .pressed(lf_pressed), .tap(lf_tap), .hold()
  );
  button_classifier #(.HOLD_CYC(HOLD_CYC)) u_step (
    .mclk(mclk), .nrst(nrst), .pin(step_button),
    .pressed(step_pressed), .tap(step_tap), .hold()
  );
  button_classifier #(.HOLD_CYC(HOLD_CYC)) u_both (
    .mclk(mclk), .nrst(nrst), .pin(lf_pressed & step_pressed),
    .pressed(), .tap(), .hold(both_hold)
  );

  // ****************************************
  // per-cylinder detection
  // ****************************************
  // unpack sample, rise and peak conditions
  always_comb begin
    for (int i = 0; i < N; i++) begin
      cur[i] = exhaust_temp[i*TW +: TW];
      rise_now[i] = (cur[i] >= base_q[i] + peak_search_pkg::RISE_DEG);
      new_peak[i] = sample_valid && tracking && risen_q[i] && !peaked_q[i] &&
                    (cur[i] < max_q[i]) && (drop_q[i] == peak_search_pkg::DROP_N - 2'h1);
    end
  end

  assign tracking = (state_q == peak_search_pkg::ST_ACTIVE) || (state_q == peak_search_pkg::ST_LOP_RUN);

  // running maximum and consecutive-drop count; reset at every arming
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      risen_q <= '0;
      peaked_q <= '0;
      for (int i = 0; i < N; i++) begin
        base_q[i] <= 12'h000;
        max_q[i] <= 12'h000;
        drop_q[i] <= 2'h0;
      end
    end else if (arm) begin
      risen_q <= '0;
      peaked_q <= '0;
      for (int i = 0; i < N; i++) begin
        base_q[i] <= cur[i];
        max_q[i] <= cur[i];
        drop_q[i] <= 2'h0;
      end
    end else if (sample_valid && state_q != peak_search_pkg::ST_IDLE) begin
      peaked_q <= peaked_q | new_peak;
      for (int i = 0; i < N; i++) begin
        if (rise_now[i]) begin
          risen_q[i] <= 1'b1;
        end
        // a peaked cylinder keeps its latched maximum
        if (!peaked_q[i] && cur[i] > max_q[i]) begin
          max_q[i] <= cur[i];
        end
        if (cur[i] < max_q[i] && !peaked_q[i]) begin
          drop_q[i] <= drop_q[i] + 2'h1;
        end else begin
          drop_q[i] <= 2'h0;
        end
      end
    end
  end

  // hottest cylinder and lowest/highest index of new peaks
  always_comb begin
    hot_idx = 3'h0;
    hot_temp = cur[0];
    new_lo = 3'h0;
    new_hi = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (new_peak[i]) begin
        new_lo = 3'(i);
      end
    end
    for (int i = 0; i < N; i++) begin
      if (cur[i] > hot_temp) begin
        hot_temp = cur[i];
        hot_idx = 3'(i);
      end
      if (new_peak[i]) begin
        new_hi = 3'(i);
      end
    end
  end

  // order of peaks and the fuel flow at first and last
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      first_q <= 3'h0;
      last_q <= 3'h0;
      ff_first_q <= 12'h000;
      ff_last_q <= 12'h000;
    end else if (|new_peak) begin
      if (peaked_q == '0) begin
        first_q <= new_lo;
        ff_first_q <= fuel_flow;
      end
      last_q <= new_hi;
      ff_last_q <= fuel_flow;
    end
  end

  assign peak_val = max_q[first_q];
  assign spread = ff_first_q - ff_last_q;

  // inverted column depth, saturating at the column height
  always_comb begin
    logic [TW-1:0] seg;
    seg = 12'h000;
    depth_d = 24'h00_0000;
    for (int i = 0; i < N; i++) begin
      seg = (max_q[i] - cur[i]) / peak_search_pkg::SEG_DEG;
      if (!peaked_q[i] || cur[i] >= max_q[i]) begin
        depth_d[i*4 +: 4] = 4'h0;
      end else if (seg > 12'(peak_search_pkg::DEPTH_MAX)) begin
        depth_d[i*4 +: 4] = peak_search_pkg::DEPTH_MAX;
      end else begin
        depth_d[i*4 +: 4] = seg[3:0];
      end
    end
  end

  // ****************************************
  // mode sequence
  // ****************************************
  assign arm = ((state_q == peak_search_pkg::ST_IDLE) || (state_q == peak_search_pkg::ST_LOP_BAR)) &&
               lf_tap && !step_tap;

  // step tap wins over every other event while in the mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= peak_search_pkg::ST_IDLE;
      timer_q <= 32'h0000_0000;
      scan_resume <= 1'b0;
    end else begin
      scan_resume <= 1'b0;
      if (state_q != peak_search_pkg::ST_IDLE && step_tap) begin
        state_q <= peak_search_pkg::ST_IDLE;
        scan_resume <= 1'b1;
      end else begin
        unique case (state_q)
          peak_search_pkg::ST_IDLE: begin
            if (arm) begin
              state_q <= peak_search_pkg::ST_ARMED;
            end
          end
          peak_search_pkg::ST_ARMED: begin
            if (|rise_now && sample_valid) begin
              state_q <= peak_search_pkg::ST_ACTIVE;
            end
          end
          peak_search_pkg::ST_ACTIVE: begin
            if (|new_peak) begin
              state_q <= lop_q ? peak_search_pkg::ST_LOP_RUN : peak_search_pkg::ST_LEANEST;
              timer_q <= LEANEST_CYC - 1;
            end
          end
          peak_search_pkg::ST_LEANEST: begin
            if (timer_q == 32'h0000_0000) begin
              state_q <= peak_search_pkg::ST_SET;
            end else begin
              timer_q <= timer_q - 32'h0000_0001;
            end
          end
          peak_search_pkg::ST_SET: begin
            state_q <= peak_search_pkg::ST_SET;
          end
          peak_search_pkg::ST_LOP_RUN: begin
            if ((peaked_q | new_peak) == ALL) begin
              state_q <= peak_search_pkg::ST_LOP_DONE;
            end
          end
          peak_search_pkg::ST_LOP_DONE: begin
            if (lf_tap) begin
              state_q <= peak_search_pkg::ST_LOP_BAR;
            end
          end
          peak_search_pkg::ST_LOP_BAR: begin
            if (arm) begin
              state_q <= peak_search_pkg::ST_ARMED;
            end
          end
        endcase
      end
    end
  end

  // method: rich on entry from idle, kept on restart from the bar graph; toggled only while armed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      lop_q <= 1'b0;
    end else if (state_q == peak_search_pkg::ST_IDLE && arm) begin
      lop_q <= 1'b0;
    end else if (state_q == peak_search_pkg::ST_ARMED && both_hold && !step_tap) begin
      lop_q <= ~lop_q;
    end
  end

  // ****************************************
  // display
  // ****************************************
  // every display output is registered from the current mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      readout_left <= 12'h000;
      readout_right <= 12'h000;
      right_label <= peak_search_pkg::LBL_BLANK;
      dot_flash <= 6'h00;
      column_flash <= 6'h00;
      column_invert <= 1'b0;
      invert_depth <= 24'h00_0000;
      lean_method <= 1'b0;
    end else begin
      readout_left <= 12'h000;
      readout_right <= 12'h000;
      right_label <= peak_search_pkg::LBL_BLANK;
      dot_flash <= 6'h00;
      column_flash <= 6'h00;
      column_invert <= 1'b0;
      invert_depth <= 24'h00_0000;
      lean_method <= lop_q;
      unique case (state_q)
        peak_search_pkg::ST_IDLE: begin
          readout_left <= 12'h000;
        end
        peak_search_pkg::ST_ARMED: begin
          readout_left <= hot_temp;
          right_label <= lop_q ? peak_search_pkg::LBL_LEAN : peak_search_pkg::LBL_RICH;
        end
        peak_search_pkg::ST_ACTIVE: begin
          readout_left <= hot_temp;
          dot_flash <= 6'h01 << hot_idx;
          readout_right <= fuel_flow;
          right_label <= ff_opt_q ? peak_search_pkg::LBL_FLOW : peak_search_pkg::LBL_ACTIVE;
        end
        peak_search_pkg::ST_LEANEST: begin
          readout_left <= cur[first_q];
          right_label <= peak_search_pkg::LBL_LEANEST;
        end
        peak_search_pkg::ST_SET: begin
          column_flash <= 6'h01 << first_q;
          dot_flash <= 6'h01 << first_q;
          readout_right <= fuel_flow;
          if (lf_pressed) begin
            readout_left <= peak_val;
            right_label <= peak_search_pkg::LBL_PEAK;
          end else begin
            readout_left <= cur[first_q];
            right_label <= ff_opt_q ? peak_search_pkg::LBL_FLOW : peak_search_pkg::LBL_SET;
          end
        end
        peak_search_pkg::ST_LOP_RUN: begin
          column_invert <= 1'b1;
          invert_depth <= depth_d;
          dot_flash <= peaked_q;
          readout_left <= cur[first_q];
          readout_right <= fuel_flow;
          right_label <= ff_opt_q ? peak_search_pkg::LBL_FLOW : peak_search_pkg::LBL_SET;
        end
        peak_search_pkg::ST_LOP_DONE: begin
          column_invert <= 1'b1;
          invert_depth <= depth_d;
          dot_flash <= peaked_q;
          column_flash <= 6'h01 << last_q;
          if (lf_pressed) begin
            readout_left <= peak_val;
            readout_right <= spread;
            right_label <= peak_search_pkg::LBL_PEAK;
          end else begin
            readout_left <= cur[first_q];
            readout_right <= fuel_flow;
            right_label <= ff_opt_q ? peak_search_pkg::LBL_FLOW : peak_search_pkg::LBL_SET;
          end
        end
        peak_search_pkg::ST_LOP_BAR: begin
          column_invert <= 1'b1;
          invert_depth <= depth_d;
          dot_flash <= peaked_q;
        end
      endcase
    end
  end

  // ****************************************
  // register bus
  // ****************************************
  // single-wait slave: ack one cycle after the strobe, then dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ff_opt_q <= peak_search_pkg::CTRL_FF_RST;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == peak_search_pkg::ADR_CTRL) begin
          ff_opt_q <= wb_dat_i[peak_search_pkg::CTRL_FF_BIT];
        end
        unique case (wb_adr_i)
          peak_search_pkg::ADR_CTRL: wb_dat_o <= {31'h0000_0000, ff_opt_q};
          peak_search_pkg::ADR_STAT: wb_dat_o <= {16'h0000, first_q, last_q, peaked_q, lop_q, state_q};
          peak_search_pkg::ADR_PEAK: wb_dat_o <= {20'h0_0000, peak_val};
          peak_search_pkg::ADR_FLOW: wb_dat_o <= {20'h0_0000, spread};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_arm_entry: assert property (state_q == peak_search_pkg::ST_IDLE && lf_tap && !step_tap
    |=> state_q == peak_search_pkg::ST_ARMED && !lop_q)
    else $error("arming did not enter armed with rich method");
  a_method_lock: assert property (!(state_q inside {peak_search_pkg::ST_IDLE, peak_search_pkg::ST_ARMED})
    |=> lop_q == $past(lop_q))
    else $error("method changed after leaning began");
  a_method_toggle: assert property (state_q == peak_search_pkg::ST_ARMED && both_hold && !step_tap
    |=> lop_q != $past(lop_q))
    else $error("dual hold did not toggle method");
  a_active_dot: assert property (state_q == peak_search_pkg::ST_ACTIVE
    |=> $countones(dot_flash) == 1 && readout_left == $past(hot_temp))
    else $error("active state without single hottest dot");
  a_step_exit: assert property (state_q != peak_search_pkg::ST_IDLE && step_tap
    |=> state_q == peak_search_pkg::ST_IDLE && scan_resume)
    else $error("step tap did not end peak search");
  a_first_peak: assert property (state_q == peak_search_pkg::ST_ACTIVE && |new_peak && !step_tap
    |=> state_q inside {peak_search_pkg::ST_LEANEST, peak_search_pkg::ST_LOP_RUN})
    else $error("first peak not taken");
  a_leanest_end: assert property (state_q == peak_search_pkg::ST_LEANEST && timer_q == 32'h0000_0000
    && !step_tap |=> state_q == peak_search_pkg::ST_SET ##1 right_label != peak_search_pkg::LBL_LEANEST)
    else $error("leanest period did not end in set");
  a_peak_shown: assert property (state_q == peak_search_pkg::ST_SET && lf_pressed
    |=> readout_left == $past(peak_val) && right_label == peak_search_pkg::LBL_PEAK)
    else $error("stored peak not shown while held");
  a_wb_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle");

endmodule
`default_nettype wire

/* test/pilot_probe_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// pilot buttons and probes
// ****************
module pilot_probe_model (
  input wire logic mclk,
  output logic peak_search_button,
  output logic step_button,
  output logic sample_valid,
  output logic [71:0] exhaust_temp,
  output logic [11:0] fuel_flow
);
  // buttons up and no sample at time zero
  initial begin
    peak_search_button = 1'b0;
    step_button = 1'b0;
    sample_valid = 1'b0;
    exhaust_temp = 72'h0;
    fuel_flow = 12'h0;
  end

  // a tap or hold is only a press length; both pins move together
  task btn(input logic p, input logic s);
    @(posedge mclk);
    peak_search_button <= p;
    step_button <= s;
  endtask

  // probes and one valid pulse set on the same edge, then four quiet cycles per sample set
  task smp(input logic [71:0] t, input logic [11:0] f, input logic v);
    @(posedge mclk);
    exhaust_temp <= t;
    fuel_flow <= f;
    sample_valid <= v;
    @(posedge mclk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [3:0] src; logic [31:0] val; logic [31:0] msk;} note_s;
  logic mclk, nrst, cyc, stb, we, ack, look, column_invert, scan_resume, lean_method;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic peak_search_button, step_button, sample_valid;
  logic [71:0] exhaust_temp;
  logic [11:0] fuel_flow, readout_left, readout_right, f1, f2;
  peak_search_pkg::label_e right_label;
  logic [5:0] dot_flash, column_flash;
  logic [23:0] invert_depth;
  logic [11:0] base [6];
  note_s q[$];
  note_s n;
  int failures, samples_checked, cycles, resumes, seed;

  // short counts keep the run brief
  mixture_peak_search_fsm #(.LEANEST_CYC(20), .HOLD_CYC(16)) i_dut (
    .mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .peak_search_button(peak_search_button), .step_button(step_button),
    .sample_valid(sample_valid), .exhaust_temp(exhaust_temp), .fuel_flow(fuel_flow),
    .readout_left(readout_left), .readout_right(readout_right), .right_label(right_label),
    .dot_flash(dot_flash), .column_flash(column_flash), .column_invert(column_invert),
    .invert_depth(invert_depth), .lean_method(lean_method), .scan_resume(scan_resume));

  pilot_probe_model i_pm (.mclk(mclk), .peak_search_button(peak_search_button),
    .step_button(step_button), .sample_valid(sample_valid), .exhaust_temp(exhaust_temp),
    .fuel_flow(fuel_flow));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ****************
  // helpers
  // ****************
  task test_done();
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = rdat;
      4'h1: obs = 32'(readout_left);
      4'h2: obs = 32'(readout_right);
      4'h3: obs = 32'(right_label);
      4'h4: obs = 32'(dot_flash);
      4'h5: obs = 32'(column_flash);
      4'h6: obs = 32'(invert_depth);
      4'h7: obs = 32'(resumes);
      4'h9: obs = 32'(lean_method);
      default: obs = 32'(column_invert);
    endcase
  endfunction

  // cylinder temps: offset o, or v on cylinders in mask m
  function automatic logic [71:0] tp(input logic [11:0] o, input logic [5:0] m, input logic [11:0] v);
    for (int i = 0; i < 6; i++) tp[12*i +: 12] = base[i] + (m[i] ? v : o);
  endfunction

  // classic cycle: hold everything until ack is sampled, then release
  task bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
           input logic [31:0] e, input logic [31:0] m);
    if (!w) q.push_back('{4'h0, e, m});
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task st(input logic [31:0] v);
    bus(1'b0, peak_search_pkg::ADR_STAT, 4'hF, 32'h0, v, 32'h000F);
  endtask

  // note the expectation, then let the watcher sample the port
  task ex(input logic [3:0] s, input logic [31:0] v);
    q.push_back('{s, v, 32'hFFFF_FFFF});
    @(posedge mclk);
    look <= 1'b1;
    @(posedge mclk);
    look <= 1'b0;
  endtask

  task tap(input logic p, input logic s, input int c);
    i_pm.btn(p, s);
    repeat (c) @(posedge mclk);
    i_pm.btn(1'b0, 1'b0);
    repeat (8) @(posedge mclk);
  endtask

  // watcher: bus reads and port looks pop the oldest note; a hang ends the run
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (scan_resume === 1'b1) resumes <= resumes + 1;
    if ((ack === 1'b1 && we === 1'b0) || look === 1'b1) begin
      n = q.pop_front();
      chk(obs(n.src) & n.msk, n.val & n.msk);
    end
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  // ****************
  // scenarios
  // ****************
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, look, adr, sel, wdat} = '0;
    {failures, samples_checked, cycles, resumes} = '0;
    seed = 39;
    for (int i = 0; i < 6; i++) base[i] = 12'h3E8 + 12'(16 * i) + 12'($random(seed) & 3);
    f1 = 12'($random(seed));
    f2 = 12'($random(seed));
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    // option bit ignored without sel, unmapped and read-only places
    bus(1'b1, peak_search_pkg::ADR_CTRL, 4'h0, 32'h1, 32'h0, 32'h0);
    bus(1'b0, peak_search_pkg::ADR_CTRL, 4'hF, 32'h0, 32'h0, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, 4'hF, 32'h0, 32'h0, 32'hFFFF_FFFF);
    bus(1'b1, peak_search_pkg::ADR_STAT, 4'hF, 32'hFFFF, 32'h0, 32'h0);
    st(32'h0);
    // rich of peak: arm, toggle twice, rise, first peak on a cooler cylinder
    i_pm.smp(tp(12'h0, 6'h0, 12'h0), f1, 1'b0);
    tap(1'b1, 1'b0, 3);
    st(32'h1);
    ex(4'h3, 32'(peak_search_pkg::LBL_RICH));
    ex(4'h1, 32'(base[5]));
    tap(1'b1, 1'b1, 22);
    st(32'h9);
    ex(4'h3, 32'(peak_search_pkg::LBL_LEAN));
    tap(1'b1, 1'b1, 22);
    st(32'h1);
    i_pm.smp(tp(12'h00E, 6'h0, 12'h0), f1, 1'b1);
    st(32'h1);
    i_pm.smp(tp(12'h014, 6'h0, 12'h0), f1, 1'b1);
    st(32'h2);
    ex(4'h4, 32'h20);
    ex(4'h3, 32'(peak_search_pkg::LBL_ACTIVE));
    tap(1'b1, 1'b1, 22);
    st(32'h2);
    bus(1'b1, peak_search_pkg::ADR_CTRL, 4'h1, 32'h1, 32'h0, 32'h0);
    i_pm.smp(tp(12'h014, 6'h04, 12'h019), f1, 1'b1);
    i_pm.smp(tp(12'h015, 6'h04, 12'h016), f1, 1'b1);
    i_pm.smp(tp(12'h016, 6'h04, 12'h015), f1, 1'b1);
    st(32'h3);
    ex(4'h3, 32'(peak_search_pkg::LBL_LEANEST));
    repeat (24) @(posedge mclk);
    st(32'h4);
    ex(4'h5, 32'h04);
    ex(4'h3, 32'(peak_search_pkg::LBL_FLOW));
    ex(4'h2, 32'(f1));
    i_pm.smp(tp(12'h017, 6'h0, 12'h0), f2, 1'b1);
    ex(4'h1, 32'(base[2] + 12'h017));
    bus(1'b0, peak_search_pkg::ADR_PEAK, 4'hF, 32'h0, 32'(base[2] + 12'h019), 32'h0FFF);
    i_pm.btn(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    ex(4'h3, 32'(peak_search_pkg::LBL_PEAK));
    ex(4'h1, 32'(base[2] + 12'h019));
    tap(1'b0, 1'b0, 1);
    tap(1'b0, 1'b1, 3);
    st(32'h0);
    ex(4'h7, 32'h1);
    // lean of peak: first cylinder peaks alone, the rest together later
    i_pm.smp(tp(12'h0, 6'h0, 12'h0), f1, 1'b0);
    tap(1'b1, 1'b0, 3);
    st(32'h1);
    tap(1'b1, 1'b1, 22);
    st(32'h9);
    ex(4'h9, 32'h1);
    i_pm.smp(tp(12'h014, 6'h0, 12'h0), f1, 1'b1);
    i_pm.smp(tp(12'h01E, 6'h0, 12'h0), f1, 1'b1);
    i_pm.smp(tp(12'h023, 6'h01, 12'h019), f1, 1'b1);
    i_pm.smp(tp(12'h028, 6'h01, 12'h014), f1, 1'b1);
    st(32'hD);
    ex(4'h8, 32'h1);
    ex(4'h4, 32'h01);
    i_pm.smp(tp(12'h023, 6'h01, 12'h014), f2, 1'b1);
    i_pm.smp(tp(12'h01E, 6'h01, 12'h014), f2, 1'b1);
    st(32'hE);
    ex(4'h6, 32'h0022_2222);
    ex(4'h5, 32'h20);
    bus(1'b0, peak_search_pkg::ADR_FLOW, 4'hF, 32'h0, 32'(12'(f1 - f2)), 32'h0FFF);
    i_pm.btn(1'b1, 1'b0);
    repeat (4) @(posedge mclk);
    ex(4'h2, 32'(12'(f1 - f2)));
    ex(4'h1, 32'(base[0] + 12'h01E));
    tap(1'b0, 1'b0, 1);
    st(32'hF);
    tap(1'b1, 1'b0, 3);
    st(32'h9);
    test_done();
  end
endmodule
`default_nettype wire
